// >>> hdl/clock_monitor_pkg.sv
package clock_monitor_pkg;
   localparam logic [7:0] RTC_DIV_OFFSET        = 8'h70;
   localparam logic [7:0] RTC_SELECTED_OFFSET   = 8'h74;
   localparam logic [7:0] RECOVERY_CTRL_OFFSET  = 8'h78;
   localparam logic [7:0] RECOVERY_STATE_OFFSET = 8'h7C;
   localparam logic [7:0] FC_REF_KHZ_OFFSET     = 8'h80;
   localparam logic [7:0] FC_MIN_KHZ_OFFSET     = 8'h84;
   localparam logic [7:0] FC_MAX_KHZ_OFFSET     = 8'h88;
   localparam logic [7:0] FC_DELAY_OFFSET       = 8'h8C;
   localparam logic [7:0] FC_INTERVAL_OFFSET    = 8'h90;
   localparam logic [7:0] FC_SOURCE_OFFSET      = 8'h94;
   localparam logic [7:0] FC_STATUS_OFFSET      = 8'h98;
   localparam logic [7:0] FC_RESULT_OFFSET      = 8'h9C;
   localparam logic [7:0] IRQ_STATUS_OFFSET     = 8'hC0;
   localparam logic [7:0] IRQ_ENABLE_OFFSET     = 8'hC4;
   localparam logic [7:0] IRQ_CLEAR_OFFSET      = 8'hC8;

   localparam int RTC_INT_LSB        = 8;
   localparam int RECOVERY_CLEAR_BIT = 16;
   localparam int RECOVERY_FORCE_BIT = 12;
   localparam int RECOVERY_EN_BIT    = 8;
   localparam int ST_PASS_BIT        = 0;
   localparam int ST_DONE_BIT        = 4;
   localparam int ST_RUNNING_BIT     = 8;
   localparam int ST_WAITING_BIT     = 12;
   localparam int ST_FAIL_BIT        = 16;
   localparam int ST_SLOW_BIT        = 20;
   localparam int ST_FAST_BIT        = 24;
   localparam int ST_DIED_BIT        = 28;
   localparam int IRQ_RECOVERED_BIT  = 0;
   localparam int IRQ_FC_DONE_BIT    = 1;

   localparam logic [23:0] RTC_INT_RESET       = 24'h000001;
   localparam logic [7:0]  RTC_FRACTION_RESET  = 8'h00;
   localparam logic [31:0] RTC_SELECTED_VALUE  = 32'h00000001;
   localparam logic [7:0]  RECOVERY_TIMEOUT_RESET = 8'hFF;
   localparam logic [24:0] FC_MAX_KHZ_RESET    = 25'h1FFFFFF;
   localparam logic [2:0]  FC_DELAY_RESET      = 3'h1;
   localparam logic [3:0]  FC_INTERVAL_RESET   = 4'h8;
   localparam logic [7:0]  FC_SOURCE_MAX       = 8'h0D;
   // zero integer divisor means 2^16
   localparam logic [16:0] RTC_ZERO_DIVISOR    = 17'h10000;
   // kHz * 2^n / 1024 ref cycles per interval; result has 5 fraction bits
   localparam int KHZ_INTERVAL_SHIFT = 10;
   localparam int RESULT_FINE_BITS   = 5;

   typedef enum logic [2:0] {FC_IDLE, FC_SETTLE, FC_WAIT, FC_COUNT, FC_DONE} fc_state_t;
endpackage

// >>> hdl/clock_monitor_rtc_divider.sv
// Design decision made here: the strobed register port.
module clock_monitor_rtc_divider #(
   parameter int NUM_TEST_CLOCKS = 13
) (
   input  wire logic                       clock_in,
   input  wire logic                       sys_rst_in,
   input  wire logic [7:0]                 reg_addr_in,
   input  wire logic [31:0]                reg_wdata_in,
   input  wire logic                       reg_write_in,
   input  wire logic                       reg_read_in,
   input  wire logic [NUM_TEST_CLOCKS-1:0] test_clocks_in,
   input  wire logic                       sysclk_heartbeat_in,
   output logic [31:0]                     reg_rdata_out,
   output logic                            rtc_tick_out,
   output logic                            sysclk_recovery_out,
   output logic                            irq_out
);
   // register file
   logic [23:0] rtc_int_q, rtc_int_d;
   logic [7:0]  divisor_fraction_part_q, divisor_fraction_part_d;
   logic        recovery_clear_q, recovery_clear_d;
   logic        recovery_force_q, recovery_force_d;
   logic        recovery_en_q, recovery_en_d;
   logic [7:0]  recovery_timeout_q, recovery_timeout_d;
   logic [19:0] ref_khz_q, ref_khz_d;
   logic [24:0] min_khz_q, min_khz_d;
   logic [24:0] max_khz_q, max_khz_d;
   logic [2:0]  settle_q, settle_d;
   logic [3:0]  interval_q, interval_d;
   logic [7:0]  source_q, source_d;
   logic [1:0]  irq_status_q, irq_status_d;
   logic [1:0]  irq_enable_q, irq_enable_d;
   logic [31:0] rdata_q, rdata_d;
   logic        irq_q, irq_d;
   logic        start_q, start_d;

   logic [31:0] fc_status;
   logic [29:0] fc_result_q, fc_result_d;
   logic        recovered_flag_q, recovered_flag_d;
   logic        recovered_event;
   logic        fc_done_event;

   always_comb begin
      rtc_int_d               = rtc_int_q;
      divisor_fraction_part_d = divisor_fraction_part_q;
      recovery_clear_d        = recovery_clear_q;
      recovery_force_d        = recovery_force_q;
      recovery_en_d           = recovery_en_q;
      recovery_timeout_d      = recovery_timeout_q;
      ref_khz_d               = ref_khz_q;
      min_khz_d               = min_khz_q;
      max_khz_d               = max_khz_q;
      settle_d                = settle_q;
      interval_d              = interval_q;
      source_d                = source_q;
      irq_enable_d            = irq_enable_q;
      start_d                 = 1'b0;
      irq_status_d            = irq_status_q;
      if (reg_write_in && reg_addr_in == clock_monitor_pkg::IRQ_CLEAR_OFFSET) begin
         irq_status_d = irq_status_q & ~reg_wdata_in[1:0];
      end
      // set wins over clear
      if (recovered_event) begin
         irq_status_d[clock_monitor_pkg::IRQ_RECOVERED_BIT] = 1'b1;
      end
      if (fc_done_event) begin
         irq_status_d[clock_monitor_pkg::IRQ_FC_DONE_BIT] = 1'b1;
      end
      if (reg_write_in) begin
         case (reg_addr_in)
            clock_monitor_pkg::RTC_DIV_OFFSET: begin
               rtc_int_d               = reg_wdata_in[31:8];
               divisor_fraction_part_d = reg_wdata_in[7:0];
            end
            clock_monitor_pkg::RECOVERY_CTRL_OFFSET: begin
               recovery_clear_d   = reg_wdata_in[clock_monitor_pkg::RECOVERY_CLEAR_BIT];
               recovery_force_d   = reg_wdata_in[clock_monitor_pkg::RECOVERY_FORCE_BIT];
               recovery_en_d      = reg_wdata_in[clock_monitor_pkg::RECOVERY_EN_BIT];
               recovery_timeout_d = reg_wdata_in[7:0];
            end
            clock_monitor_pkg::FC_REF_KHZ_OFFSET:  ref_khz_d  = reg_wdata_in[19:0];
            clock_monitor_pkg::FC_MIN_KHZ_OFFSET:  min_khz_d  = reg_wdata_in[24:0];
            clock_monitor_pkg::FC_MAX_KHZ_OFFSET:  max_khz_d  = reg_wdata_in[24:0];
            clock_monitor_pkg::FC_DELAY_OFFSET:    settle_d   = reg_wdata_in[2:0];
            clock_monitor_pkg::FC_INTERVAL_OFFSET: interval_d = reg_wdata_in[3:0];
            clock_monitor_pkg::FC_SOURCE_OFFSET: begin
               source_d = reg_wdata_in[7:0];
               start_d  = 1'b1;
            end
            clock_monitor_pkg::IRQ_ENABLE_OFFSET:  irq_enable_d = reg_wdata_in[1:0];
            default: ;
         endcase
      end
      rdata_d = 32'h00000000;
      if (reg_read_in) begin
         case (reg_addr_in)
            clock_monitor_pkg::RTC_DIV_OFFSET:        rdata_d = {rtc_int_q, divisor_fraction_part_q};
            clock_monitor_pkg::RTC_SELECTED_OFFSET:   rdata_d = clock_monitor_pkg::RTC_SELECTED_VALUE;
            clock_monitor_pkg::RECOVERY_CTRL_OFFSET:  rdata_d = {15'h0000, recovery_clear_q, 3'h0, recovery_force_q,
                                                                 3'h0, recovery_en_q, recovery_timeout_q};
            clock_monitor_pkg::RECOVERY_STATE_OFFSET: rdata_d = {31'h00000000, recovered_flag_q};
            clock_monitor_pkg::FC_REF_KHZ_OFFSET:     rdata_d = {12'h000, ref_khz_q};
            clock_monitor_pkg::FC_MIN_KHZ_OFFSET:     rdata_d = {7'h00, min_khz_q};
            clock_monitor_pkg::FC_MAX_KHZ_OFFSET:     rdata_d = {7'h00, max_khz_q};
            clock_monitor_pkg::FC_DELAY_OFFSET:       rdata_d = {29'h00000000, settle_q};
            clock_monitor_pkg::FC_INTERVAL_OFFSET:    rdata_d = {28'h0000000, interval_q};
            clock_monitor_pkg::FC_SOURCE_OFFSET:      rdata_d = {24'h000000, source_q};
            clock_monitor_pkg::FC_STATUS_OFFSET:      rdata_d = fc_status;
            clock_monitor_pkg::FC_RESULT_OFFSET:      rdata_d = {2'h0, fc_result_q};
            clock_monitor_pkg::IRQ_STATUS_OFFSET:     rdata_d = {30'h00000000, irq_status_q};
            clock_monitor_pkg::IRQ_ENABLE_OFFSET:     rdata_d = {30'h00000000, irq_enable_q};
            default:                                  rdata_d = 32'h00000000;
         endcase
      end
      irq_d = |(irq_status_d & irq_enable_d);
   end
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rtc_int_q               <= clock_monitor_pkg::RTC_INT_RESET;
         divisor_fraction_part_q <= clock_monitor_pkg::RTC_FRACTION_RESET;
         recovery_clear_q        <= 1'b0;
         recovery_force_q        <= 1'b0;
         recovery_en_q           <= 1'b0;
         recovery_timeout_q      <= clock_monitor_pkg::RECOVERY_TIMEOUT_RESET;
         ref_khz_q               <= 20'h00000;
         min_khz_q               <= 25'h0000000;
         max_khz_q               <= clock_monitor_pkg::FC_MAX_KHZ_RESET;
         settle_q                <= clock_monitor_pkg::FC_DELAY_RESET;
         interval_q              <= clock_monitor_pkg::FC_INTERVAL_RESET;
         source_q                <= 8'h00;
         irq_status_q            <= 2'h0;
         irq_enable_q            <= 2'h0;
         rdata_q                 <= 32'h00000000;
         irq_q                   <= 1'b0;
         start_q                 <= 1'b0;
      end else begin
         rtc_int_q               <= rtc_int_d;
         divisor_fraction_part_q <= divisor_fraction_part_d;
         recovery_clear_q        <= recovery_clear_d;
         recovery_force_q        <= recovery_force_d;
         recovery_en_q           <= recovery_en_d;
         recovery_timeout_q      <= recovery_timeout_d;
         ref_khz_q               <= ref_khz_d;
         min_khz_q               <= min_khz_d;
         max_khz_q               <= max_khz_d;
         settle_q                <= settle_d;
         interval_q              <= interval_d;
         source_q                <= source_d;
         irq_status_q            <= irq_status_d;
         irq_enable_q            <= irq_enable_d;
         rdata_q                 <= rdata_d;
         irq_q                   <= irq_d;
         start_q                 <= start_d;
      end
   end
   assign reg_rdata_out = rdata_q;
   assign irq_out       = irq_q;

   // rtc fractional divider: period is int cycles, plus one when fraction carries
   logic [23:0] rtc_cnt_q, rtc_cnt_d;
   logic [7:0]  rtc_acc_q, rtc_acc_d;
   logic        rtc_tick_q, rtc_tick_d;
   logic [24:0] rtc_period;
   logic [8:0]  rtc_acc_sum;
   always_comb begin
      rtc_period  = (rtc_int_q == 24'h000000) ? {8'h00, clock_monitor_pkg::RTC_ZERO_DIVISOR}
                                              : {1'b0, rtc_int_q};
      rtc_acc_sum = {1'b0, rtc_acc_q} + {1'b0, divisor_fraction_part_q};
      rtc_cnt_d   = rtc_cnt_q + 24'h000001;
      rtc_acc_d   = rtc_acc_q;
      rtc_tick_d  = 1'b0;
      // divisor compared live every cycle with >=, so a write never stalls the output
      if ({1'b0, rtc_cnt_q} + 25'h0000001 >= rtc_period + {24'h000000, rtc_acc_sum[8]}) begin
         rtc_cnt_d  = 24'h000000;
         rtc_acc_d  = rtc_acc_sum[7:0];
         rtc_tick_d = 1'b1;
      end
   end
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rtc_cnt_q  <= 24'h000000;
         rtc_acc_q  <= 8'h00;
         rtc_tick_q <= 1'b0;
      end else begin
         rtc_cnt_q  <= rtc_cnt_d;
         rtc_acc_q  <= rtc_acc_d;
         rtc_tick_q <= rtc_tick_d;
      end
   end
   assign rtc_tick_out = rtc_tick_q;

   // system clock recovery monitor
   logic [1:0] hb_sync_q;
   logic       hb_prev_q;
   logic [7:0] stall_cnt_q, stall_cnt_d;
   logic       hb_edge;
   always_comb begin
      hb_edge          = hb_sync_q[1] ^ hb_prev_q;
      stall_cnt_d      = stall_cnt_q;
      recovered_event  = 1'b0;
      if (!recovery_en_q || hb_edge) begin
         stall_cnt_d = 8'h00;
      end else if (stall_cnt_q != 8'hFF) begin
         stall_cnt_d = stall_cnt_q + 8'h01;
      end
      if (recovery_en_q && !hb_edge && stall_cnt_q >= recovery_timeout_q) begin
         recovered_event = 1'b1;
      end
      if (reg_write_in && reg_addr_in == clock_monitor_pkg::RECOVERY_CTRL_OFFSET &&
          reg_wdata_in[clock_monitor_pkg::RECOVERY_FORCE_BIT]) begin
         recovered_event = 1'b1;
      end
      recovered_flag_d = recovered_flag_q;
      if (reg_write_in && reg_addr_in == clock_monitor_pkg::RECOVERY_CTRL_OFFSET &&
          reg_wdata_in[clock_monitor_pkg::RECOVERY_CLEAR_BIT]) begin
         recovered_flag_d = 1'b0;
      end
      if (recovered_event) begin
         recovered_flag_d = 1'b1;
      end
   end
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         hb_sync_q        <= 2'h0;
         hb_prev_q        <= 1'b0;
         stall_cnt_q      <= 8'h00;
         recovered_flag_q <= 1'b0;
      end else begin
         hb_sync_q        <= {hb_sync_q[0], sysclk_heartbeat_in};
         hb_prev_q        <= hb_sync_q[1];
         stall_cnt_q      <= stall_cnt_d;
         recovered_flag_q <= recovered_flag_d;
      end
   end
   assign sysclk_recovery_out = recovered_flag_q;

   // test clock synchronisers
   logic [NUM_TEST_CLOCKS-1:0] tc_meta_q;
   logic [NUM_TEST_CLOCKS-1:0] tc_sync_q;

   for (genvar i = 0; i < NUM_TEST_CLOCKS; i++) begin : g_tc_sync
      always_ff @(posedge clock_in) begin
         if (sys_rst_in) begin
            tc_meta_q[i] <= 1'b0;
            tc_sync_q[i] <= 1'b0;
         end else begin
            tc_meta_q[i] <= test_clocks_in[i];
            tc_sync_q[i] <= tc_meta_q[i];
         end
      end
   end

   // frequency counter
   clock_monitor_pkg::fc_state_t fc_state_q, fc_state_d;
   logic        sel_clk_q, sel_clk_d;
   logic        sel_prev_q;
   logic [25:0] ref_cnt_q, ref_cnt_d;
   logic [25:0] edge_cnt_q, edge_cnt_d;
   logic        pass_q, pass_d;
   logic        fail_q, fail_d;
   logic        fast_q, fast_d;
   logic        slow_q, slow_d;
   logic        died_q, died_d;
   logic [25:0] interval_cycles;
   logic [45:0] interval_wide;
   logic [45:0] result_wide;
   logic [24:0] result_khz;
   logic        sel_edge;
   logic        sel_valid;
   always_comb begin
      sel_valid = source_q != 8'h00 && source_q <= clock_monitor_pkg::FC_SOURCE_MAX;
      sel_clk_d = sel_valid ? tc_sync_q[source_q[3:0] - 4'h1] : 1'b0;
      sel_edge        = sel_clk_q && !sel_prev_q;
      interval_wide   = ({26'h0000000, ref_khz_q} << interval_q) >> clock_monitor_pkg::KHZ_INTERVAL_SHIFT;
      interval_cycles = (interval_wide[25:0] == 26'h0000000) ? 26'h0000001 : interval_wide[25:0];
      result_wide     = ({20'h00000, edge_cnt_q} <<
                         (clock_monitor_pkg::KHZ_INTERVAL_SHIFT + clock_monitor_pkg::RESULT_FINE_BITS)) >> interval_q;
      result_khz      = result_wide[29:5];
      fc_state_d      = fc_state_q;
      ref_cnt_d       = ref_cnt_q + 26'h0000001;
      edge_cnt_d      = edge_cnt_q;
      fc_result_d     = fc_result_q;
      pass_d          = pass_q;
      fail_d          = fail_q;
      fast_d          = fast_q;
      slow_d          = slow_q;
      died_d          = died_q;
      fc_done_event   = 1'b0;
      case (fc_state_q)
         clock_monitor_pkg::FC_IDLE, clock_monitor_pkg::FC_DONE: ;
         clock_monitor_pkg::FC_SETTLE: begin
            if (ref_cnt_q >= {23'h000000, settle_q}) begin
               fc_state_d = clock_monitor_pkg::FC_WAIT;
               ref_cnt_d  = 26'h0000000;
            end
         end
         clock_monitor_pkg::FC_WAIT: begin
            if (sel_edge) begin
               fc_state_d = clock_monitor_pkg::FC_COUNT;
               ref_cnt_d  = 26'h0000000;
               edge_cnt_d = 26'h0000000;
            end else if (ref_cnt_q >= interval_cycles) begin
               fc_state_d    = clock_monitor_pkg::FC_DONE;
               died_d        = 1'b1;
               fail_d        = 1'b1;
               slow_d        = 1'b1;
               fc_done_event = 1'b1;
            end
         end
         clock_monitor_pkg::FC_COUNT: begin
            if (sel_edge) begin
               edge_cnt_d = edge_cnt_q + 26'h0000001;
            end
            if (ref_cnt_q + 26'h0000001 >= interval_cycles) begin
               fc_state_d    = clock_monitor_pkg::FC_DONE;
               fc_result_d   = result_wide[29:0];
               fc_done_event = 1'b1;
               died_d        = edge_cnt_q == 26'h0000000;
               slow_d        = result_khz < min_khz_q;
               fast_d        = result_khz > max_khz_q;
               pass_d        = !(result_khz < min_khz_q) && !(result_khz > max_khz_q);
               fail_d        = !pass_d;
            end
         end
         default: fc_state_d = clock_monitor_pkg::FC_IDLE;
      endcase
      if (start_q) begin
         fc_state_d = sel_valid ? clock_monitor_pkg::FC_SETTLE : clock_monitor_pkg::FC_IDLE;
         ref_cnt_d  = 26'h0000000;
         edge_cnt_d = 26'h0000000;
         pass_d     = 1'b0;
         fail_d     = 1'b0;
         fast_d     = 1'b0;
         slow_d     = 1'b0;
         died_d     = 1'b0;
      end
      fc_status = 32'h00000000;
      fc_status[clock_monitor_pkg::ST_PASS_BIT]    = pass_q;
      fc_status[clock_monitor_pkg::ST_DONE_BIT]    = fc_state_q == clock_monitor_pkg::FC_DONE;
      fc_status[clock_monitor_pkg::ST_RUNNING_BIT] = fc_state_q == clock_monitor_pkg::FC_SETTLE ||
                                                     fc_state_q == clock_monitor_pkg::FC_WAIT ||
                                                     fc_state_q == clock_monitor_pkg::FC_COUNT;
      fc_status[clock_monitor_pkg::ST_WAITING_BIT] = fc_state_q == clock_monitor_pkg::FC_WAIT;
      fc_status[clock_monitor_pkg::ST_FAIL_BIT]    = fail_q;
      fc_status[clock_monitor_pkg::ST_SLOW_BIT]    = slow_q;
      fc_status[clock_monitor_pkg::ST_FAST_BIT]    = fast_q;
      fc_status[clock_monitor_pkg::ST_DIED_BIT]    = died_q;
   end
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         fc_state_q  <= clock_monitor_pkg::FC_IDLE;
         sel_clk_q   <= 1'b0;
         sel_prev_q  <= 1'b0;
         ref_cnt_q   <= 26'h0000000;
         edge_cnt_q  <= 26'h0000000;
         fc_result_q <= 30'h00000000;
         pass_q      <= 1'b0;
         fail_q      <= 1'b0;
         fast_q      <= 1'b0;
         slow_q      <= 1'b0;
         died_q      <= 1'b0;
      end else begin
         fc_state_q  <= fc_state_d;
         sel_clk_q   <= sel_clk_d;
         sel_prev_q  <= sel_clk_q;
         ref_cnt_q   <= ref_cnt_d;
         edge_cnt_q  <= edge_cnt_d;
         fc_result_q <= fc_result_d;
         pass_q      <= pass_d;
         fail_q      <= fail_d;
         fast_q      <= fast_d;
         slow_q      <= slow_d;
         died_q      <= died_d;
      end
   end
endmodule

// >>> testbench/clock_monitor_sva.sv
module clock_monitor_sva (
   input wire logic        clock_in,
   input wire logic        sys_rst_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_write_in,
   input wire logic        reg_read_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        sysclk_recovery_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   logic ctl_wr;
   logic st_rd;
   assign ctl_wr = reg_write_in && reg_addr_in == 8'h78;
   assign st_rd  = reg_read_in && reg_addr_in == 8'h98;
   a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 32'h0) else $error("rdata not zero");
   a_selected_one: assert property (reg_read_in && reg_addr_in == 8'h74 |=> reg_rdata_out == 32'h1)
      else $error("selected source not one");
   a_unmapped_zero: assert property (reg_read_in && reg_addr_in == 8'h50 |=> reg_rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (reg_read_in && reg_addr_in inside {8'h8C, 8'h90, 8'h94}
      |=> reg_rdata_out[31:8] == 24'h0) else $error("reserved bits set");
   a_force_sets: assert property (ctl_wr && reg_wdata_in[12] |=> sysclk_recovery_out)
      else $error("force did not recover");
   a_clear_drops: assert property (ctl_wr && reg_wdata_in[16] && !reg_wdata_in[12] && !reg_wdata_in[8]
      |=> !sysclk_recovery_out) else $error("clear did not drop");
   a_recovery_holds: assert property (sysclk_recovery_out && !(ctl_wr && reg_wdata_in[16])
      |=> sysclk_recovery_out) else $error("recovered state lost");
   a_flags_need_done: assert property (st_rd |=> reg_rdata_out[4] || (reg_rdata_out & 32'h01110001) == 32'h0)
      else $error("result flags without done");
   a_pass_or_fail: assert property (st_rd ##1 reg_rdata_out[4]
      |-> reg_rdata_out[0] != (reg_rdata_out[16] && (reg_rdata_out[20] || reg_rdata_out[24])))
      else $error("pass and fail inconsistent");
endmodule
bind clock_monitor_rtc_divider clock_monitor_sva clock_monitor_sva_i (.clock_in, .sys_rst_in, .reg_addr_in,
   .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .sysclk_recovery_out);

// >>> testbench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_in = 0, sys_rst_in = 1, reg_write_in = 0, reg_read_in = 0, hb_run = 1;
   logic        sysclk_heartbeat_in = 0;
   logic [7:0]  reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0, v, d;
   logic [12:0] test_clocks_in = 13'h0;
   wire logic [31:0] reg_rdata_out;
   wire logic   rtc_tick_out, sysclk_recovery_out, irq_out;
   int          fail_count = 0, comparisons = 0, seed = 32'h1FB2A253, n, i, ph = 0, cnt, e, dv;
   logic [7:0]  ra[11] = '{8'h70, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h50};
   logic [31:0] rv[11] = '{32'h100, 32'h1, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h1FFFFFF, 32'h1, 32'h8, 32'h0, 32'h0};
   logic [31:0] rm[11] = '{32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'hFFFFF, 32'h1FFFFFF, 32'h1FFFFFF, 32'h7, 32'hF,
                           32'hFF, 32'h0};
   logic [31:0] fc[3][3] = '{'{32'd900, 32'd1100, 32'h11}, '{32'd2000, 32'h1FFFFFF, 32'h110010},
                             '{32'h0, 32'd100, 32'h1010010}};
   clock_monitor_rtc_divider clock_monitor_rtc_divider_i (.clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
      .reg_write_in, .reg_read_in, .test_clocks_in, .sysclk_heartbeat_in, .reg_rdata_out, .rtc_tick_out,
      .sysclk_recovery_out, .irq_out);
   initial forever #50 clock_in = ~clock_in;
   // source 1 runs at 1 MHz, the others random
   always @(posedge clock_in) begin
      ph <= (ph == 4) ? 0 : ph + 1;
      test_clocks_in[0] <= (ph == 4) ? ~test_clocks_in[0] : test_clocks_in[0];
      test_clocks_in[12:1] <= 12'($random(seed));
      sysclk_heartbeat_in <= hb_run ? ~sysclk_heartbeat_in : sysclk_heartbeat_in;
   end
   task chk(input string s, input logic [31:0] x, g);
      comparisons++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, x, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= w;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   task results;
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wait_done;
      for (n = 0; n < 200; n++) begin
         rd(8'h98);
         if (v[4] === 1'b1) return;
      end
      chk("fc done wait", 1, 0);
      results();
   endtask
   function int ticks_exp(input int c, q, f);
      return c * 256 / ((q == 0 ? 65536 : q) * 256 + f);
   endfunction
   initial begin
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      for (i = 0; i < 11; i++) begin
         rd(ra[i]);
         chk("reset value", rv[i], v);
         if (i == 2 || i == 3) continue;
         d = $random(seed);
         wr(ra[i], d);
         rd(ra[i]);
         chk("readback", (d & rm[i]) | (rv[i] & ~rm[i]), v);
      end
      wr(8'h94, 32'h0);
      for (i = 0; i < 5; i++) begin
         dv = (i == 0) ? 0 : 2 + ($random(seed) & 3);
         d = $random(seed) & 32'hFF;
         wr(8'h70, {dv[23:0], d[7:0]});
         repeat (10) @(posedge clock_in);
         cnt = 0;
         repeat (300) begin
            @(posedge clock_in);
            #1 cnt += rtc_tick_out;
         end
         e = ticks_exp(300, dv, d);
         chk("rtc ticks", 1, cnt >= e - 1 && cnt <= e + 1);
      end
      wr(8'hC4, 32'h1);
      wr(8'h78, 32'h10FF);
      rd(8'h7C);
      chk("recovered", 1, v);
      chk("irq raised", 1, irq_out);
      wr(8'h78, 32'h10000);
      rd(8'h7C);
      chk("recovered clear", 0, v);
      chk("irq sticky", 1, irq_out);
      wr(8'hC8, 32'h3);
      rd(8'hC0);
      chk("irq status", 0, v);
      wr(8'hC4, 32'h0);
      wr(8'h78, 32'h1000);
      rd(8'hC0);
      chk("irq masked", 0, irq_out);
      chk("irq status set", 1, v);
      wr(8'h78, 32'h10110);
      repeat (60) @(posedge clock_in);
      chk("no stall", 0, sysclk_recovery_out);
      hb_run <= 1'b0;
      for (n = 0; n < 40 && sysclk_recovery_out !== 1'b1; n++) @(posedge clock_in) #1;
      chk("timeout", 1, n >= 16 && n < 40);
      hb_run <= 1'b1;
      wr(8'h78, 32'h10);
      wr(8'h78, 32'h10000);
      wr(8'hC8, 32'h3);
      wr(8'hC4, 32'h2);
      wr(8'h80, 32'h2710);
      wr(8'h8C, 32'h2);
      wr(8'h90, 32'h4);
      for (i = 1; i <= 13; i++) begin
         wr(8'h84, 32'h0);
         wr(8'h88, 32'h1FFFFFF);
         wr(8'h94, i);
         wait_done();
         chk("fc pass", 32'h11, v & 32'h11110011);
      end
      chk("irq fc done", 1, irq_out);
      for (i = 0; i < 3; i++) begin
         wr(8'h84, fc[i][0]);
         wr(8'h88, fc[i][1]);
         wr(8'h94, 32'h1);
         wait_done();
         chk("fc status", fc[i][2], v & 32'h11110011);
         rd(8'h9C);
         chk("fc khz", 1, v[29:5] >= 900 && v[29:5] <= 1100);
      end
      wr(8'h94, 32'h0);
      repeat (300) @(posedge clock_in);
      rd(8'h98);
      chk("fc idle", 0, v[4]);
      results();
   end
endmodule
